// >>> verilog/uart_rx_pkg.sv
// Purpose: Shared constants and state encodings for the serial receive and break block.
// Assumes: One system clock; the line input is already synchronous to it.
// Notes:   The design body lives in uart_rx_break.sv.
//
// Functional notes
// - Break starts only after the request bit stays high over divisor+1 clocks.
// - A break is a start bit, then multiples of 13 zeros, then stop bits.
// - Sending a break never raises a transmit interrupt.
// - While the request stays high, break characters follow back to back; the code repeats only the 13 zeros, with no new start bit.
// - After the request drops, finish the current break, then send one or two stops.
// - Words are 8 or 9 bits; in 9-bit mode the top bit goes to its own field.
// - Recovery runs at sixteen ticks per bit; the shifter moves once per bit.
// - Each bit level is a majority vote of three line samples.
// - After the stop bit the shifted word moves into the buffer if it has room.
// - Serial data arrives least significant bit first.
// - The buffer holds two words while a third is shifted in.
// - A third word finishing into a full buffer is dropped and overrun set.
// - Setting receive enable starts the search for a start bit.
// - The data available flag is high whenever the buffer holds a word.
// - A word entering the buffer with interrupt enable set requests an interrupt.
// - An overrun also requests an interrupt when interrupt enable is set.
// - Data available clears only after a status read followed by a data read.
// - A received break is a framing error and ends after data bits plus a stop.
// - A break loads a zero word and sets available, framing and idle flags.
// - After a break wait for a high line before seeking the next start bit.
// - A low stop bit sets framing error; with two stops both must be high.
// - With parity on, a parity mismatch against odd or even sets parity error.
// - Noise in a frame sets the noise flag with the word, data still transferred.
package uart_rx_pkg;

  localparam int          OS_RATE      = 16;      // Oversampling ticks per bit.
  localparam logic [3:0]  OS_LAST      = 4'hf;    // Last tick of a bit period.
  localparam logic [3:0]  SAMPLE_FIRST = 4'h7;    // First of three vote samples.
  localparam logic [3:0]  SAMPLE_LAST  = 4'h9;    // Last of three vote samples.
  localparam logic [3:0]  DECIDE_TICK  = 4'ha;    // Tick at which the vote is read.
  localparam logic [3:0]  BREAK_ZEROS  = 4'hd;    // Zero bits per break group.
  localparam logic [3:0]  BITS_SHORT   = 4'h8;    // Bits in a short word.
  localparam logic [3:0]  BITS_LONG    = 4'h9;    // Bits in a long word.
  localparam int          WORD_W       = 9;       // Widest received word.
  localparam int          ENTRY_W      = 12;      // Word plus its three error flags.
  localparam int          FIFO_DEPTH   = 2;       // Receive buffer entries.
  localparam int          DIV_W        = 8;       // Baud divisor width.

  // Receive sequencer states, one-hot.
  typedef enum logic [4:0] {
    RX_SEEK  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_STOP  = 5'h08,
    RX_WAIT  = 5'h10
  } rx_state_e;

  // Break transmitter states, one-hot.
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_ZERO  = 4'h4,
    TX_STOP  = 4'h8
  } tx_state_e;

endpackage

// >>> verilog/uart_rx_break.sv
// Purpose: Serial receive path with two-word buffer, plus break character generation.
// Assumes: receive_line_pin is synchronous to sys_clk; controls are static levels.
// Notes:   One bit lasts sixteen oversampling ticks of (baud_divisor+1) clocks each.
`timescale 1ns/1ps

module rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // Pointer wrap relies on a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("rx_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [CNT_W-1:0]            cnt;
  } fifo_s;

  fifo_s q;
  fifo_s d;

  assign in_ready  = (q.cnt != CNT_W'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];

  // Push and pop may share a cycle; the count then stays put.
  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    d    = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = q.wr + PTR_W'(1);
    end
    if (pop) begin
      d.rd = q.rd + PTR_W'(1);
    end
    if (push && !pop) begin
      d.cnt = q.cnt + CNT_W'(1);
    end else if (pop && !push) begin
      d.cnt = q.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module uart_rx_break #(
  parameter int DIV_W = uart_rx_pkg::DIV_W,
  parameter int DEPTH = uart_rx_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             receive_line_pin,
  input  wire logic [DIV_W-1:0] baud_divisor,
  input  wire logic             receiver_enable_bit,
  input  wire logic             word_length_select,
  input  wire logic             parity_enable_bit,
  input  wire logic             parity_type_select,
  input  wire logic             two_stop_select,
  input  wire logic             receive_interrupt_enable,
  input  wire logic             break_request_bit,
  input  wire logic             status_read,
  input  wire logic             data_read,
  output logic [7:0]            data_buffer_register,
  output logic                  received_ninth_bit,
  output logic                  receive_available_flag,
  output logic                  overrun_flag,
  output logic                  framing_error_flag,
  output logic                  parity_error_flag,
  output logic                  noise_flag,
  output logic                  receiver_idle_flag,
  output logic                  rx_irq,
  output logic                  tx_line
);
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_param
    $error("uart_rx_break divisor width must lie in 1..16");
  end

  typedef struct packed {
    logic [DIV_W-1:0]              os_div;
    uart_rx_pkg::rx_state_e        rx_state;
    logic [3:0]                    rx_os;
    logic [3:0]                    rx_bit;
    logic [uart_rx_pkg::WORD_W-1:0] shift;
    logic [2:0]                    votes;
    logic                          line_prev;
    logic                          noisy;
    logic                          stop_two;
    logic [DIV_W:0]                brk_cnt;
    logic                          brk_armed;
    uart_rx_pkg::tx_state_e        tx_state;
    logic [3:0]                    tx_os;
    logic [3:0]                    tx_cnt;
    logic                          tx_stop2;
    logic                          tx_line;
    logic                          seen_status;
    logic                          avail;
    logic                          ovr;
    logic                          ferr;
    logic                          perr;
    logic                          nf;
    logic                          idle;
    logic                          irq;
    logic [7:0]                    dout;
    logic                          ninth;
  } top_s;

  top_s q;
  top_s d;

  logic                             push;
  logic                             push_ready;
  logic [uart_rx_pkg::ENTRY_W-1:0]  push_word;
  logic                             head_valid;
  logic                             pop;
  logic [uart_rx_pkg::ENTRY_W-1:0]  head_word;

  // Received words wait here; a full buffer is what turns a finished word into an overrun.
  rx_fifo #(
    .WIDTH (uart_rx_pkg::ENTRY_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head_word)
  );

  // A data read only pops when a status read came first.
  assign pop = data_read && q.seen_status && head_valid;

  // Main next-state logic for receiver, buffer flags and break transmitter.
  always_comb begin
    logic                          tick;
    logic                          maj;
    logic [3:0]                    nbits;
    logic [uart_rx_pkg::WORD_W-1:0] word;
    logic                          perr_now;
    logic                          stop_err;
    logic                          finish;
    tick      = (q.os_div == '0);
    maj       = (q.votes[0] & q.votes[1]) | (q.votes[0] & q.votes[2]) |
                (q.votes[1] & q.votes[2]);
    nbits     = word_length_select ? uart_rx_pkg::BITS_LONG : uart_rx_pkg::BITS_SHORT;
    word      = word_length_select ? q.shift : {1'b0, q.shift[8:1]};
    perr_now  = parity_enable_bit && ((^word) != parity_type_select);
    stop_err  = 1'b0;
    finish    = 1'b0;
    push      = 1'b0;
    push_word = '0;
    d         = q;
    d.irq     = 1'b0;

    // One oversampling tick every divisor+1 clocks, sixteen per bit.
    d.os_div = tick ? baud_divisor : q.os_div - DIV_W'(1);

    // Receive sequencer; every step waits on an oversampling tick.
    if (!receiver_enable_bit) begin
      d.rx_state  = uart_rx_pkg::RX_SEEK;
      d.line_prev = 1'b1;
      d.idle      = 1'b1;
    end else if (tick) begin
      d.line_prev = receive_line_pin;
      d.rx_os     = q.rx_os + 4'h1;
      if (q.rx_os >= uart_rx_pkg::SAMPLE_FIRST && q.rx_os <= uart_rx_pkg::SAMPLE_LAST) begin
        d.votes = {q.votes[1:0], receive_line_pin};
      end
      case (q.rx_state)
        uart_rx_pkg::RX_SEEK: begin
          d.rx_os = 4'h0;
          if (q.line_prev && !receive_line_pin) begin
            d.rx_state = uart_rx_pkg::RX_START;
            d.rx_os    = 4'h1;
            d.noisy    = 1'b0;
            d.idle     = 1'b0;
          end
        end
        uart_rx_pkg::RX_START: begin
          if (q.rx_os == uart_rx_pkg::DECIDE_TICK) begin
            if (maj) begin
              d.rx_state = uart_rx_pkg::RX_SEEK; // False start, a glitch only.
              d.idle     = 1'b1;
            end
            d.noisy = q.noisy | ~(&q.votes | ~|q.votes);
          end else if (q.rx_os == uart_rx_pkg::OS_LAST) begin
            d.rx_state = uart_rx_pkg::RX_DATA;
            d.rx_bit   = 4'h0;
          end
        end
        uart_rx_pkg::RX_DATA: begin
          if (q.rx_os == uart_rx_pkg::DECIDE_TICK) begin
            d.shift = {maj, q.shift[8:1]};
            d.noisy = q.noisy | ~(&q.votes | ~|q.votes);
          end else if (q.rx_os == uart_rx_pkg::OS_LAST) begin
            d.rx_bit = q.rx_bit + 4'h1;
            if (q.rx_bit == nbits - 4'h1) begin
              d.rx_state = uart_rx_pkg::RX_STOP;
              d.stop_two = 1'b0;
            end
          end
        end
        uart_rx_pkg::RX_STOP: begin
          if (q.rx_os == uart_rx_pkg::DECIDE_TICK) begin
            d.noisy = q.noisy | ~(&q.votes | ~|q.votes);
            if (!maj) begin
              stop_err = 1'b1;
              finish   = 1'b1;
            end else if (two_stop_select && !q.stop_two) begin
              d.stop_two = 1'b1;
            end else begin
              finish = 1'b1;
            end
          end else if (q.rx_os == uart_rx_pkg::OS_LAST) begin
            d.rx_os = 4'h0; // Second stop bit follows.
          end
        end
        uart_rx_pkg::RX_WAIT: begin
          d.rx_os = 4'h0;
          if (receive_line_pin) begin
            d.rx_state  = uart_rx_pkg::RX_SEEK;
            d.line_prev = 1'b1;
          end
        end
        default: begin
          d.rx_state = uart_rx_pkg::RX_SEEK;
        end
      endcase
    end

    // Word complete: queue it with its flags, or drop it on a full buffer.
    if (finish) begin
      d.idle     = 1'b1;
      d.rx_state = stop_err ? uart_rx_pkg::RX_WAIT : uart_rx_pkg::RX_SEEK;
      d.line_prev = 1'b1;
      push_word  = {stop_err, perr_now, d.noisy, word};
      if (push_ready) begin
        push  = 1'b1;
        d.irq = receive_interrupt_enable;
      end else begin
        d.ovr = 1'b1;
        d.irq = receive_interrupt_enable;
      end
    end

    // Buffer head is mirrored into registered outputs one clock later.
    d.avail = head_valid;
    d.dout  = head_word[7:0];
    d.ninth = head_word[8];
    d.ferr  = head_valid & head_word[11];
    d.perr  = head_valid & head_word[10];
    d.nf    = head_valid & head_word[9];

    // Status then data read clears the sticky overrun; a new overrun wins.
    if (status_read) begin
      d.seen_status = 1'b1;
    end else if (data_read) begin
      d.seen_status = 1'b0;
      if (q.seen_status && !(finish && !push_ready)) begin
        d.ovr = 1'b0;
      end
    end

    // Break request must be held longer than one divisor period before arming.
    if (!break_request_bit) begin
      d.brk_cnt = '0;
    end else if (q.brk_cnt <= {1'b0, baud_divisor}) begin
      d.brk_cnt = q.brk_cnt + (DIV_W + 1)'(1);
    end else begin
      d.brk_armed = 1'b1;
    end
    if (!break_request_bit) begin
      d.brk_armed = 1'b0;
    end

    // Break transmitter; it has no interrupt output at all.
    if (tick) begin
      d.tx_os = q.tx_os + 4'h1;
      case (q.tx_state)
        uart_rx_pkg::TX_IDLE: begin
          d.tx_os   = 4'h0;
          d.tx_line = 1'b1;
          if (q.brk_armed) begin
            d.tx_state = uart_rx_pkg::TX_START;
            d.tx_line  = 1'b0;
          end
        end
        uart_rx_pkg::TX_START: begin
          if (q.tx_os == uart_rx_pkg::OS_LAST) begin
            d.tx_state = uart_rx_pkg::TX_ZERO;
            d.tx_cnt   = 4'h0;
          end
        end
        uart_rx_pkg::TX_ZERO: begin
          if (q.tx_os == uart_rx_pkg::OS_LAST) begin
            d.tx_cnt = q.tx_cnt + 4'h1;
            if (q.tx_cnt == uart_rx_pkg::BREAK_ZEROS - 4'h1) begin
              d.tx_cnt = 4'h0;
              if (!break_request_bit) begin
                d.tx_state = uart_rx_pkg::TX_STOP;
                d.tx_line  = 1'b1;
                d.tx_stop2 = two_stop_select;
              end
            end
          end
        end
        uart_rx_pkg::TX_STOP: begin
          if (q.tx_os == uart_rx_pkg::OS_LAST) begin
            if (q.tx_stop2) begin
              d.tx_stop2 = 1'b0;
            end else begin
              d.tx_state = uart_rx_pkg::TX_IDLE;
            end
          end
        end
        default: begin
          d.tx_state = uart_rx_pkg::TX_IDLE;
          d.tx_line  = 1'b1;
        end
      endcase
    end
    // Holding the request keeps the zero groups running back to back.
    if (q.tx_state == uart_rx_pkg::TX_ZERO && break_request_bit) begin
      d.tx_line = 1'b0;
    end
  end

  // All state in one register; the idle line levels come out high.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q           <= '0;
      q.rx_state  <= uart_rx_pkg::RX_SEEK;
      q.tx_state  <= uart_rx_pkg::TX_IDLE;
      q.line_prev <= 1'b1;
      q.tx_line   <= 1'b1;
      q.idle      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign data_buffer_register   = q.dout;
  assign received_ninth_bit     = q.ninth;
  assign receive_available_flag = q.avail;
  assign overrun_flag           = q.ovr;
  assign framing_error_flag     = q.ferr;
  assign parity_error_flag      = q.perr;
  assign noise_flag             = q.nf;
  assign receiver_idle_flag     = q.idle;
  assign rx_irq                 = q.irq;
  assign tx_line                = q.tx_line;
endmodule

// >>> testbench/far_end_line.sv
// Purpose: Remote serial transmitter that drives the block's receive line.
// Assumes: One bit lasts BITC system clocks; the bench calls the tasks at falling edges.
// Notes:   The line rests high between frames, as an idle pulled-up line would.
`timescale 1ns/1ps

module far_end_line #(
  parameter int BITC = 32
) (
  input  wire logic sys_clk,
  output logic      line
);
  initial line = 1'b1;

  // Holds one level for whole bit times.
  task automatic hold(input logic lvl, input int nb);
    line = lvl;
    repeat (nb * BITC) @(negedge sys_clk);
  endtask

  // Start bit, n bits least significant first, then one stop level that is left standing.
  // A glitch on bit g lasts two clocks, so it can spoil only one of the three votes.
  task automatic send(input logic [8:0] d, input int n, input logic stp, input int g);
    hold(1'b0, 1);
    for (int i = 0; i < n; i++) begin
      line = d[i];
      repeat (BITC / 2) @(negedge sys_clk);
      if (i == g) line = ~d[i];
      repeat (2) @(negedge sys_clk);
      line = d[i];
      repeat (BITC / 2 - 2) @(negedge sys_clk);
    end
    hold(stp, 1);
  endtask
endmodule

// >>> testbench/uart_rx_break_chk.sv
// Purpose: Concurrent checks on the ports of the receive and break block.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes:   Bound to every instance of the block below the module.
`timescale 1ns/1ps

module uart_rx_break_chk #(
  parameter int DIV_W = 8
) (
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             receive_line_pin,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic             receiver_enable_bit,
  input wire logic             two_stop_select,
  input wire logic             receive_interrupt_enable,
  input wire logic             break_request_bit,
  input wire logic             status_read,
  input wire logic             data_read,
  input wire logic             receive_available_flag,
  input wire logic             overrun_flag,
  input wire logic             framing_error_flag,
  input wire logic             noise_flag,
  input wire logic             receiver_idle_flag,
  input wire logic             rx_irq,
  input wire logic             tx_line
);
  logic        armed_q;
  logic        stop2_q;
  logic [2:0]  pop_q;
  logic [19:0] low_q;
  logic [19:0] high_q;
  logic [19:0] req_q;
  logic [19:0] bitc;

  // One bit period in clocks.
  assign bitc = (20'(baud_divisor) + 20'h1) << 4;

  // Run lengths of the break line and the request; a pop needs a status read first.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
      stop2_q <= 1'b0;
      pop_q   <= 3'h0;
      low_q   <= 20'h0;
      high_q  <= 20'h0;
      req_q   <= 20'h0;
    end else begin
      armed_q <= status_read | (armed_q & ~data_read);
      stop2_q <= tx_line ? stop2_q : two_stop_select; // Stop count is fixed as the group ends.
      pop_q   <= {pop_q[1:0], data_read & armed_q};
      low_q   <= tx_line ? 20'h0 : low_q + 20'h1;
      high_q  <= tx_line ? high_q + 20'h1 : 20'h0;
      req_q   <= break_request_bit ? req_q + 20'h1 : 20'h0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  irq_on_push_a: assert property ($rose(receive_available_flag) &&
    $past(receive_interrupt_enable, 2) |-> $past(rx_irq)) else $error("no interrupt on push");
  irq_masked_a: assert property (rx_irq |-> $past(receive_interrupt_enable))
    else $error("interrupt while disabled");
  pop_order_a: assert property ($fell(receive_available_flag) |-> |pop_q)
    else $error("data flag cleared without status then data read");
  overrun_clear_a: assert property ($fell(overrun_flag) |-> |pop_q)
    else $error("overrun cleared without read sequence");
  overrun_full_a: assert property ($rose(overrun_flag) |-> receive_available_flag)
    else $error("overrun with buffer not full");
  noise_data_a: assert property ($rose(noise_flag) |-> receive_available_flag)
    else $error("noise flag without data");
  idle_start_a: assert property ($fell(receiver_idle_flag) |->
    $past(receiver_enable_bit) && !$past(receive_line_pin)) else $error("idle cleared wrongly");
  break_arm_a: assert property ($fell(tx_line) |-> req_q > 20'(baud_divisor) + 20'h1)
    else $error("break began before request settled");
  break_len_a: assert property ($rose(tx_line) |-> low_q % bitc == 20'h0 &&
    (low_q / bitc) % 20'hd == 20'h1) else $error("break length not start plus 13 times n");
  break_stop_a: assert property ($fell(tx_line) |->
    high_q >= (stop2_q ? 20'h2 : 20'h1) * bitc) else $error("stop bits too short");

  cover property (rx_irq);
  cover property ($rose(overrun_flag));
  cover property ($rose(framing_error_flag));
  cover property ($rose(tx_line));
endmodule

bind uart_rx_break uart_rx_break_chk #(.DIV_W(DIV_W)) uart_rx_break_chk_inst (.*);

// >>> testbench/uart_rx_break_tb_top.sv
// Purpose: Self-checking bench for the receive path and break generator.
// Assumes: Divisor 1, so a tick is two clocks and a bit is 32 clocks.
// Notes:   Inputs change at falling edges; every wait is bounded.
`timescale 1ns/1ps

module uart_rx_break_tb_top;
  localparam int BITC = 32;

  logic       sys_clk;
  logic       rst;
  logic       line;
  logic [7:0] div;
  logic       rx_en, wlen, par_en, par_odd, two_stop, rie, brk_req, st_rd, dt_rd;
  logic [7:0] dbuf;
  logic       ninth, avail, ovr, ferr, perr, nf, idle, irq, txl;
  int         miscompares = 0;
  int         compares = 0;
  int         irqs = 0;

  uart_rx_break uart_rx_break_inst (
    .sys_clk(sys_clk), .rst(rst), .receive_line_pin(line), .baud_divisor(div),
    .receiver_enable_bit(rx_en), .word_length_select(wlen), .parity_enable_bit(par_en),
    .parity_type_select(par_odd), .two_stop_select(two_stop),
    .receive_interrupt_enable(rie), .break_request_bit(brk_req), .status_read(st_rd),
    .data_read(dt_rd), .data_buffer_register(dbuf), .received_ninth_bit(ninth),
    .receive_available_flag(avail), .overrun_flag(ovr), .framing_error_flag(ferr),
    .parity_error_flag(perr), .noise_flag(nf), .receiver_idle_flag(idle), .rx_irq(irq),
    .tx_line(txl)
  );

  far_end_line #(.BITC(BITC)) far_end_line_inst (.sys_clk(sys_clk), .line(line));

  // Free-running 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Interrupt pulses last one clock, so counting edges counts requests.
  always @(posedge sys_clk) if (irq === 1'b1) irqs++;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Software read: an optional status access, then a data access.
  task automatic rd(input logic with_status);
    st_rd = with_status;
    @(negedge sys_clk);
    st_rd = 1'b0;
    dt_rd = 1'b1;
    @(negedge sys_clk);
    dt_rd = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  // Compares the head word and its error flags.
  task automatic head(input logic [7:0] d, input logic f, input logic p, input logic n);
    chk("data", 16'(dbuf), 16'(d));
    chk("framing", 16'(ferr), 16'(f));
    chk("parity", 16'(perr), 16'(p));
    chk("noise", 16'(nf), 16'(n));
  endtask

  // Holds the break request for h bits after the line falls; measures the low time.
  task automatic brk(input int h, input int exp_bits);
    int c;
    c = 0;
    brk_req = 1'b1;
    while (txl !== 1'b0 && c < 4 * BITC) begin
      @(negedge sys_clk);
      c++;
    end
    chk("break start", 16'(txl), 16'h0);
    if (txl !== 1'b0) test_done();
    c = 0;
    while (txl === 1'b0 && c < 40 * BITC) begin
      if (c == h * BITC) brk_req = 1'b0;
      c++;
      @(negedge sys_clk);
    end
    chk("break length", 16'(c), 16'(exp_bits * BITC));
    if (txl === 1'b0) test_done();
  endtask

  initial begin
    rst = 1'b1;
    div = 8'h01;
    {rx_en, wlen, par_en, par_odd, two_stop, brk_req, st_rd, dt_rd} = 8'h00;
    rie = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk("idle", 16'(idle), 16'h1);
    chk("break line", 16'(txl), 16'h1);
    // With the receiver off a frame is ignored; once on it is taken.
    far_end_line_inst.send(9'h077, 8, 1'b1, -1);
    chk("available", 16'(avail), 16'h0);
    rx_en = 1'b1;
    far_end_line_inst.send(9'h0a5, 8, 1'b1, -1);
    chk("available", 16'(avail), 16'h1);
    head(8'ha5, 1'b0, 1'b0, 1'b0);
    chk("idle", 16'(idle), 16'h1);
    chk("irq count", 16'(irqs), 16'h1);
    rd(1'b0);
    chk("available", 16'(avail), 16'h1);
    rd(1'b1);
    chk("available", 16'(avail), 16'h0);
    // Three words back to back with no reads: the third is dropped.
    for (int i = 1; i < 4; i++) far_end_line_inst.send(9'(8'h11 * i), 8, 1'b1, -1);
    chk("overrun", 16'(ovr), 16'h1);
    chk("irq count", 16'(irqs), 16'h4);
    head(8'h11, 1'b0, 1'b0, 1'b0);
    rd(1'b1);
    chk("overrun", 16'(ovr), 16'h0);
    head(8'h22, 1'b0, 1'b0, 1'b0);
    rd(1'b1);
    chk("available", 16'(avail), 16'h0);
    // Nine-bit word with the interrupt masked.
    {wlen, rie} = 2'h2;
    far_end_line_inst.send(9'h1c3, 9, 1'b1, -1);
    chk("ninth", 16'(ninth), 16'h1);
    head(8'hc3, 1'b0, 1'b0, 1'b0);
    chk("irq count", 16'(irqs), 16'h4);
    rd(1'b1);
    {wlen, rie, par_en} = 3'h3;
    // One set bit: wrong for even parity, right for odd.
    for (int t = 0; t < 2; t++) begin
      par_odd = t[0];
      far_end_line_inst.send(9'h001, 8, 1'b1, -1);
      chk("parity", 16'(perr), 16'(!par_odd));
      rd(1'b1);
    end
    par_en = 1'b0;
    // One spoiled vote still gives the right bit, but marks noise.
    far_end_line_inst.send(9'h05a, 8, 1'b1, 3);
    head(8'h5a, 1'b0, 1'b0, 1'b1);
    rd(1'b1);
    far_end_line_inst.send(9'h03c, 8, 1'b0, -1);
    far_end_line_inst.hold(1'b1, 1);
    head(8'h3c, 1'b1, 1'b0, 0);
    rd(1'b1);
    two_stop = 1'b1;
    far_end_line_inst.send(9'h1c3, 9, 1'b0, -1);
    far_end_line_inst.hold(1'b1, 1);
    head(8'hc3, 1'b1, 1'b0, 1'b0);
    rd(1'b1);
    two_stop = 1'b0;
    // A long break gives one zero word and is not taken as a new start.
    far_end_line_inst.send(9'h000, 8, 1'b0, -1);
    far_end_line_inst.hold(1'b0, 6);
    head(8'h00, 1'b1, 1'b0, 1'b0);
    chk("idle", 16'(idle), 16'h1);
    chk("irq count", 16'(irqs), 16'ha);
    far_end_line_inst.hold(1'b1, 2);
    rd(1'b1);
    chk("available", 16'(avail), 16'h0);
    // A long request gives two groups; short ones give one, and two stops follow.
    brk(20, 27);
    two_stop = 1'b1;
    brk(1, 14);
    brk(1, 14);
    brk_req = 1'b1;
    @(negedge sys_clk);
    brk_req = 1'b0;
    repeat (3 * BITC) @(negedge sys_clk);
    chk("break line", 16'(txl), 16'h1);
    chk("irq count", 16'(irqs), 16'ha);
    test_done();
  end
endmodule
